// ===== design/upca_pin_alloc.sv
// user pin allocation: reset sequencing, pin sampling, control muxing
//
// Notes on behaviour
// (R1) An internal reset is produced at power-up without any external pin.
// (R2) The board pulls the reset pin low to request an external reset.
// (R3) During reset all dividers are cleared and the PLL is forced unlocked.
// (R4) Reset leaves direct fan-out outputs without division enabled; the code disables them until two clocks after the reset pin rises.
// (R5) Each user pin has its own polarity and pull-up or pull-down choice.
// (R6) Only pins zero and one can drive; pins two and three are input-only.
// (R7) Pin allocation comes from nonvolatile configuration and is applied.
// (R8) Every control but the sync gate may come from serial or a fixed bit.
// (R9) Serial control works only when its clock and data are allocated.
// (R10) With serial enabled, clock comes from pin two and data from pin one.
// (R11) Reference select picks input A at 0 and input B at 1.
// (R12) PLL bypass control bypasses the PLL at 0 and runs it at 1.
// (R13) Unpinned PLL bypass follows serial only if its config bit is 1.
// (R14) Each control has exactly one source chosen by its allocation.
// (R15) Active-low pins are inverted on input and on status output.
`timescale 1ns/10ps
module upca_pin_alloc #(
  parameter int POR_CYCLES_P = upca_pkg::POR_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [upca_pkg::NUM_PINS-1:0] i_user_pin,
  output logic [upca_pkg::NUM_BIDIR-1:0] o_user_pin,
  output logic [upca_pkg::NUM_BIDIR-1:0] o_user_pin_oe,
  output logic [upca_pkg::NUM_PINS-1:0] o_user_pull_up,
  output logic [upca_pkg::NUM_PINS-1:0] o_user_pull_dn,
  input wire logic [upca_pkg::NUM_PINS-1:0] i_nv_act_low,
  input wire logic [upca_pkg::NUM_PINS-1:0] i_nv_pull_up,
  input wire logic [upca_pkg::NUM_FN*upca_pkg::SRC_W-1:0] i_nv_fn_src,
  input wire logic [upca_pkg::NUM_FN*upca_pkg::PIN_IDX_W-1:0] i_nv_fn_pin,
  input wire logic [upca_pkg::NUM_FN-1:0] i_nv_fn_fixed,
  input wire logic i_nv_serial_en,
  input wire logic i_nv_lock_on_pin,
  input wire logic i_nv_fanout_direct,
  input wire logic [upca_pkg::NUM_FN-1:0] i_ser_ctrl,
  input wire logic i_ser_sda_pull,
  input wire logic i_pll_lock,
  output logic o_ser_enable,
  output logic o_ser_scl,
  output logic o_ser_sda,
  output logic o_ref_clock_select,
  output logic o_pll_bypass,
  output logic o_output_enable_w,
  output logic o_output_enable_x,
  output logic o_output_enable_y,
  output logic o_output_enable_z,
  output logic o_sync_gate_control,
  output logic o_core_rst_b,
  output logic o_div_clear,
  output logic o_pll_unlock_force,
  output logic o_out_disable_rst
);
  import upca_pkg::*;

  localparam logic [POR_CNT_W-1:0] POR_LAST =
    POR_CNT_W'(POR_CYCLES_P - 1);

  // reset sequencer
  upca_rst_state_type rst_state_q;
  upca_rst_state_type rst_state_d;
  logic [POR_CNT_W-1:0] por_cnt_q;
  logic [POR_CNT_W-1:0] por_cnt_d;
  logic running;

  always_comb begin
    rst_state_d = rst_state_q;
    por_cnt_d = por_cnt_q;
    case (rst_state_q)
      RST_HOLD: begin
        por_cnt_d = '0;
        rst_state_d = RST_COUNT;
      end
      RST_COUNT: begin
        // (R1) stretch internal reset
        if (por_cnt_q == POR_LAST) begin
          rst_state_d = RST_RUN;
        end else begin
          por_cnt_d = por_cnt_q + POR_CNT_W'(1);
        end
      end
      RST_RUN: begin
        rst_state_d = RST_RUN;
      end
      default: begin
        rst_state_d = RST_HOLD;
      end
    endcase
  end

  // (R2) low on reset pin restarts sequence
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_state_q <= RST_HOLD;
      por_cnt_q <= '0;
    end else begin
      rst_state_q <= rst_state_d;
      por_cnt_q <= por_cnt_d;
    end
  end

  assign running = (rst_state_q == RST_RUN);

  // configuration snapshot, caught after reset release
  logic [NUM_PINS-1:0] cfg_act_low_q;
  logic [NUM_PINS-1:0] cfg_act_low_d;
  logic [NUM_PINS-1:0] cfg_pull_up_q;
  logic [NUM_PINS-1:0] cfg_pull_up_d;
  logic [NUM_FN*SRC_W-1:0] cfg_src_q;
  logic [NUM_FN*SRC_W-1:0] cfg_src_d;
  logic [NUM_FN*PIN_IDX_W-1:0] cfg_pin_q;
  logic [NUM_FN*PIN_IDX_W-1:0] cfg_pin_d;
  logic [NUM_FN-1:0] cfg_fixed_q;
  logic [NUM_FN-1:0] cfg_fixed_d;
  logic cfg_ser_q;
  logic cfg_ser_d;
  logic cfg_lock_q;
  logic cfg_lock_d;
  logic cfg_fanout_q;
  logic cfg_fanout_d;

  always_comb begin
    cfg_act_low_d = cfg_act_low_q;
    cfg_pull_up_d = cfg_pull_up_q;
    cfg_src_d = cfg_src_q;
    cfg_pin_d = cfg_pin_q;
    cfg_fixed_d = cfg_fixed_q;
    cfg_ser_d = cfg_ser_q;
    cfg_lock_d = cfg_lock_q;
    cfg_fanout_d = cfg_fanout_q;
    // (R7) load allocation from storage
    if (!running) begin
      cfg_act_low_d = i_nv_act_low;
      cfg_pull_up_d = i_nv_pull_up;
      cfg_src_d = i_nv_fn_src;
      cfg_pin_d = i_nv_fn_pin;
      cfg_fixed_d = i_nv_fn_fixed;
      cfg_ser_d = i_nv_serial_en;
      cfg_lock_d = i_nv_lock_on_pin;
      cfg_fanout_d = i_nv_fanout_direct;
    end
  end

  // held stable while running: no glitchy reallocation mid-operation
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_act_low_q <= CFG_ACT_LOW_RST;
      cfg_pull_up_q <= CFG_PULL_UP_RST;
      cfg_src_q <= CFG_SRC_RST;
      cfg_pin_q <= CFG_PIN_RST;
      cfg_fixed_q <= FN_RST;
      cfg_ser_q <= 1'h0;
      cfg_lock_q <= 1'h0;
      cfg_fanout_q <= 1'h0;
    end else begin
      cfg_act_low_q <= cfg_act_low_d;
      cfg_pull_up_q <= cfg_pull_up_d;
      cfg_src_q <= cfg_src_d;
      cfg_pin_q <= cfg_pin_d;
      cfg_fixed_q <= cfg_fixed_d;
      cfg_ser_q <= cfg_ser_d;
      cfg_lock_q <= cfg_lock_d;
      cfg_fanout_q <= cfg_fanout_d;
    end
  end

  // pin sampling
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_PINS-1:0] pin_taken;
  logic lock_meta_q;
  logic lock_sync_q;

  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      upca_pin_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_b (i_rst_b),
        .i_pin (i_user_pin[p]),
        // (R5) per-pin polarity
        .i_act_low (cfg_act_low_q[p]),
        .o_raw (pin_raw[p]),
        .o_level (pin_lvl[p])
      );
    end
  endgenerate

  // pins claimed by the serial link are not free for controls
  always_comb begin
    pin_taken = '0;
    // (R10) clock on pin two, data on pin one
    if (cfg_ser_q) begin
      pin_taken[PIN_SCL] = 1'h1;
      pin_taken[PIN_SDA] = 1'h1;
    end
  end

  // lock comes from the analog loop, so synchronise it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_meta_q <= 1'h0;
      lock_sync_q <= 1'h0;
    end else begin
      lock_meta_q <= i_pll_lock;
      lock_sync_q <= lock_meta_q;
    end
  end

  // control source selection
  logic [NUM_FN-1:0] fn_d;
  logic [NUM_FN-1:0] fn_q;

  generate
    for (genvar f = 0; f < NUM_FN; f++) begin : g_fn
      logic [SRC_W-1:0] src;
      logic [PIN_IDX_W-1:0] pidx;
      logic fn_bit;
      always_comb begin
        src = cfg_src_q[f*SRC_W +: SRC_W];
        pidx = cfg_pin_q[f*PIN_IDX_W +: PIN_IDX_W];
        // (R14) one source per control
        case (src)
          SRC_PIN: begin
            // a pin held by the serial link falls back to fixed
            if (pin_taken[pidx]) begin
              fn_bit = cfg_fixed_q[f];
            end else begin
              // (R15) corrected level drives control
              fn_bit = pin_lvl[pidx];
            end
          end
          SRC_SERIAL: begin
            // (R8) serial drive, never the sync gate
            if (f == FN_SYNC_GATE) begin
              fn_bit = cfg_fixed_q[f];
            // (R13) bypass serial needs config bit one
            end else if (f == FN_PLL_BYPASS && !cfg_fixed_q[f]) begin
              fn_bit = cfg_fixed_q[f];
            // (R9) serial only when pins allocated
            end else if (!cfg_ser_q) begin
              fn_bit = cfg_fixed_q[f];
            end else begin
              fn_bit = i_ser_ctrl[f];
            end
          end
          SRC_FIXED: begin
            // (R8) fixed value from storage
            fn_bit = cfg_fixed_q[f];
          end
          default: begin
            fn_bit = cfg_fixed_q[f];
          end
        endcase
        if (!running) begin
          fn_bit = FN_RST[f];
        end
      end
      // one process per bit would multiply drive the vector
      assign fn_d[f] = fn_bit;
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fn_q <= FN_RST;
    end else begin
      fn_q <= fn_d;
    end
  end

  // (R11) 0 selects input A, 1 input B
  assign o_ref_clock_select = fn_q[FN_REF_CLOCK_SELECT];
  // (R12) 0 bypasses, 1 keeps PLL
  assign o_pll_bypass = fn_q[FN_PLL_BYPASS];
  assign o_output_enable_w = fn_q[FN_OUTPUT_ENABLE_W];
  assign o_output_enable_x = fn_q[FN_OUTPUT_ENABLE_X];
  assign o_output_enable_y = fn_q[FN_OUTPUT_ENABLE_Y];
  assign o_output_enable_z = fn_q[FN_OUTPUT_ENABLE_Z];
  assign o_sync_gate_control = fn_q[FN_SYNC_GATE];

  // pin drivers, serial taps and reset outputs
  logic [NUM_BIDIR-1:0] pout_d;
  logic [NUM_BIDIR-1:0] pout_q;
  logic [NUM_BIDIR-1:0] poe_d;
  logic [NUM_BIDIR-1:0] poe_q;
  logic [NUM_PINS-1:0] pu_d;
  logic [NUM_PINS-1:0] pu_q;
  logic [NUM_PINS-1:0] pd_d;
  logic [NUM_PINS-1:0] pd_q;
  logic ser_en_d;
  logic ser_en_q;
  logic scl_d;
  logic scl_q;
  logic sda_d;
  logic sda_q;
  logic rst_o_d;
  logic rst_o_q;
  logic odis_d;
  logic odis_q;

  always_comb begin
    // (R5) pull direction per pin
    pu_d = cfg_pull_up_q;
    pd_d = ~cfg_pull_up_q;
    // (R6) only pins zero and one drive
    pout_d = '0;
    poe_d = '0;
    if (running && cfg_lock_q) begin
      // (R15) status follows pin polarity
      pout_d[PIN_LOCK] = lock_sync_q ^ cfg_act_low_q[PIN_LOCK];
      poe_d[PIN_LOCK] = 1'h1;
    end
    // open-drain data: only ever pull low
    if (running && cfg_ser_q && i_ser_sda_pull) begin
      pout_d[PIN_SDA] = 1'h0;
      poe_d[PIN_SDA] = 1'h1;
    end
    // (R9) link idle high unless allocated
    ser_en_d = running && cfg_ser_q;
    scl_d = 1'h1;
    sda_d = 1'h1;
    if (ser_en_d) begin
      // (R10) raw pin levels to the link
      scl_d = pin_raw[PIN_SCL];
      sda_d = pin_raw[PIN_SDA];
    end
    // (R3) clear dividers, drop lock
    rst_o_d = running;
    // (R4) direct fan-out survives the internal stretch, not the reset pin hold
    odis_d = !running && !cfg_fanout_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pout_q <= '0;
      poe_q <= '0;
      pu_q <= CFG_PULL_UP_RST;
      pd_q <= ~CFG_PULL_UP_RST;
      ser_en_q <= 1'h0;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      rst_o_q <= 1'h0;
      odis_q <= 1'h1;
    end else begin
      pout_q <= pout_d;
      poe_q <= poe_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
      ser_en_q <= ser_en_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      rst_o_q <= rst_o_d;
      odis_q <= odis_d;
    end
  end

  assign o_user_pin = pout_q;
  assign o_user_pin_oe = poe_q;
  assign o_user_pull_up = pu_q;
  assign o_user_pull_dn = pd_q;
  assign o_ser_enable = ser_en_q;
  assign o_ser_scl = scl_q;
  assign o_ser_sda = sda_q;
  assign o_core_rst_b = rst_o_q;
  assign o_div_clear = !rst_o_q;
  assign o_pll_unlock_force = !rst_o_q;
  assign o_out_disable_rst = odis_q;
endmodule

// ===== design/upca_pkg.sv
// constants and types for the user pin control allocation block
package upca_pkg;
  localparam int NUM_PINS = 4;
  localparam int NUM_FN = 7;
  localparam int SRC_W = 2;
  localparam int PIN_IDX_W = 2;
  // function indices
  localparam int FN_REF_CLOCK_SELECT = 0;
  localparam int FN_PLL_BYPASS = 1;
  localparam int FN_OUTPUT_ENABLE_W = 2;
  localparam int FN_OUTPUT_ENABLE_X = 3;
  localparam int FN_OUTPUT_ENABLE_Y = 4;
  localparam int FN_OUTPUT_ENABLE_Z = 5;
  localparam int FN_SYNC_GATE = 6;
  // source codes of a function
  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  // fixed pin roles
  localparam int PIN_LOCK = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SCL = 2;
  localparam int NUM_BIDIR = 2;
  // control values
  localparam logic REF_CLOCK_SELECT_INPUT_A = 1'h0;
  localparam logic PLL_BYPASSED = 1'h0;
  localparam logic PLL_ACTIVE = 1'h1;
  // reset values
  localparam logic [NUM_FN-1:0] FN_RST = 7'h02;
  localparam logic [NUM_PINS-1:0] CFG_ACT_LOW_RST = 4'h0;
  localparam logic [NUM_PINS-1:0] CFG_PULL_UP_RST = 4'hf;
  localparam logic [NUM_FN*SRC_W-1:0] CFG_SRC_RST = 14'h0000;
  localparam logic [NUM_FN*PIN_IDX_W-1:0] CFG_PIN_RST = 14'h0000;
  // power-up reset stretch
  localparam int POR_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 9;
  typedef enum logic [1:0] {
    RST_HOLD,
    RST_COUNT,
    RST_RUN
  } upca_rst_state_type;
endpackage

// ===== design/upca_pin_sync.sv
// two-stage synchroniser for one user pin with polarity correction
`timescale 1ns/10ps
module upca_pin_sync (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_pin,
  input wire logic i_act_low,
  output logic o_raw,
  output logic o_level
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic lvl_q;
  logic lvl_d;

  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    // (R15) invert active-low pins
    lvl_d = sync_q ^ i_act_low;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      lvl_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      lvl_q <= lvl_d;
    end
  end

  assign o_raw = sync_q;
  assign o_level = lvl_q;
endmodule

// ===== tb/upca_pin_alloc_props.sv
// port checker for the user pin allocation block
`timescale 1ns/10ps
module upca_pin_alloc_props #(
  parameter int POR_CYCLES_P = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_user_pin,
  input wire logic [1:0] o_user_pin,
  input wire logic [1:0] o_user_pin_oe,
  input wire logic [3:0] o_user_pull_up,
  input wire logic [3:0] o_user_pull_dn,
  input wire logic [3:0] i_nv_act_low,
  input wire logic [3:0] i_nv_pull_up,
  input wire logic [13:0] i_nv_fn_src,
  input wire logic [6:0] i_nv_fn_fixed,
  input wire logic i_nv_lock_on_pin,
  input wire logic i_nv_fanout_direct,
  input wire logic [6:0] i_ser_ctrl,
  input wire logic i_pll_lock,
  input wire logic o_ser_enable,
  input wire logic o_ser_scl,
  input wire logic o_ser_sda,
  input wire logic o_ref_clock_select,
  input wire logic o_pll_bypass,
  input wire logic o_output_enable_w,
  input wire logic o_output_enable_x,
  input wire logic o_output_enable_y,
  input wire logic o_output_enable_z,
  input wire logic o_sync_gate_control,
  input wire logic o_core_rst_b,
  input wire logic o_div_clear,
  input wire logic o_pll_unlock_force,
  input wire logic o_out_disable_rst
);
  import upca_pkg::*;
  logic [6:0] ctl;
  assign ctl = {o_sync_gate_control, o_output_enable_z, o_output_enable_y,
    o_output_enable_x, o_output_enable_w, o_pll_bypass, o_ref_clock_select};
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  rst_ctl_a: assert property (!o_core_rst_b |-> ctl == FN_RST)
    else $error("controls not at reset value");
  div_clr_a: assert property (o_div_clear != o_core_rst_b
    && o_pll_unlock_force != o_core_rst_b) else $error("divider clear bad");
  por_len_a: assert property ($rose(i_rst_b) |->
    !o_core_rst_b [*4] ##[0:4] o_core_rst_b) else $error("power-up span");
  pull_cfg_a: assert property (o_core_rst_b && $past(o_core_rst_b) |->
    o_user_pull_up == i_nv_pull_up && o_user_pull_dn == ~i_nv_pull_up)
    else $error("pull select wrong");
  oe_one_a: assert property (o_user_pin_oe[1] |-> o_ser_enable)
    else $error("pin one driven without serial");
  ser_off_a: assert property (!o_ser_enable |-> o_ser_scl && o_ser_sda)
    else $error("serial taps not idle");
  scl_tap_a: assert property (o_ser_enable && $past(o_ser_enable, 3) |->
    o_ser_scl == $past(i_user_pin[2], 3)) else $error("serial clock tap");
  ser_ref_a: assert property (o_core_rst_b && $past(o_core_rst_b) &&
    o_ser_enable && i_nv_fn_src[1:0] == SRC_SERIAL |=>
    o_ref_clock_select == $past(i_ser_ctrl[0])) else $error("serial ref");
  byp_lock_a: assert property (o_core_rst_b && $past(o_core_rst_b) &&
    i_nv_fn_src[3:2] == SRC_SERIAL && !i_nv_fn_fixed[1] |-> !o_pll_bypass)
    else $error("bypass followed serial");
  gate_fix_a: assert property (o_core_rst_b && $past(o_core_rst_b) &&
    i_nv_fn_src[13:12] == SRC_SERIAL |->
    o_sync_gate_control == i_nv_fn_fixed[6]) else $error("gate on serial");
  lock_out_a: assert property (o_core_rst_b && $past(o_core_rst_b, 4) &&
    i_nv_lock_on_pin |-> o_user_pin_oe[0] &&
    o_user_pin[0] == ($past(i_pll_lock, 3) ^ i_nv_act_low[0]))
    else $error("lock pin wrong");
  fan_rst_a: assert property (!o_core_rst_b && $past(i_rst_b, 2) |->
    o_out_disable_rst == !i_nv_fanout_direct) else $error("reset disable");
  cover property ($rose(o_core_rst_b));
  cover property (o_ser_enable && o_user_pin_oe[1]);
  cover property (o_core_rst_b && i_nv_lock_on_pin);
endmodule

bind upca_pin_alloc upca_pin_alloc_props #(.POR_CYCLES_P(POR_CYCLES_P))
  u_props (.*);

// ===== tb/upca_board.sv
// board-side model resolving the four user pin wires
`timescale 1ns/10ps
module upca_board (
  input wire logic [3:0] i_drv,
  input wire logic [3:0] i_rel,
  input wire logic [1:0] i_dev_val,
  input wire logic [1:0] i_dev_oe,
  input wire logic [3:0] i_pull_up,
  output logic [3:0] o_pin
);
  always_comb begin
    // a released pin settles at its pull level
    o_pin = (i_rel & i_pull_up) | (~i_rel & i_drv);
    // device drive reaches pins zero and one only
    for (int p = 0; p < 2; p++) begin
      if (i_dev_oe[p]) begin
        o_pin[p] = i_dev_val[p];
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the user pin allocation block
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import upca_pkg::*;
  localparam int POR_CYCLES_P = 4;
  logic i_sys_clk = 0;
  logic i_rst_b = 0;
  logic [3:0] i_user_pin, drv = 0, rel = 0;
  logic [3:0] i_nv_act_low = 0, i_nv_pull_up = 0;
  logic [1:0] o_user_pin, o_user_pin_oe;
  logic [3:0] o_user_pull_up, o_user_pull_dn;
  logic [13:0] i_nv_fn_src = 0, i_nv_fn_pin = 0;
  logic [6:0] i_nv_fn_fixed = 0, i_ser_ctrl = 0, ctl;
  logic i_nv_serial_en = 0, i_nv_lock_on_pin = 0, i_nv_fanout_direct = 0;
  logic i_ser_sda_pull = 0, i_pll_lock = 0;
  logic o_ser_enable, o_ser_scl, o_ser_sda, o_ref_clock_select;
  logic o_pll_bypass, o_output_enable_w, o_output_enable_x;
  logic o_output_enable_y, o_output_enable_z, o_sync_gate_control;
  logic o_core_rst_b, o_div_clear, o_pll_unlock_force, o_out_disable_rst;
  logic [13:0] srct [4] = '{14'h1555, 14'h2aa9, 14'h2aaa, 14'h2aaa};
  int bad_count = 0;
  int n_tests = 0;
  assign ctl = {o_sync_gate_control, o_output_enable_z, o_output_enable_y,
    o_output_enable_x, o_output_enable_w, o_pll_bypass, o_ref_clock_select};
  upca_pin_alloc #(.POR_CYCLES_P(POR_CYCLES_P)) u_upca_pin_alloc (.*);
  upca_board u_upca_board (.i_drv(drv), .i_rel(rel), .i_dev_val(o_user_pin),
    .i_dev_oe(o_user_pin_oe), .i_pull_up(o_user_pull_up), .o_pin(i_user_pin));
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // expected controls from the allocation settings and pin wires
  function automatic logic [6:0] model(logic [3:0] w);
    logic [6:0] e;
    int s;
    int p;
    for (int f = 0; f < 7; f++) begin
      s = i_nv_fn_src[2*f+:2];
      p = i_nv_fn_pin[2*f+:2];
      e[f] = i_nv_fn_fixed[f];
      // pins one and two are lost to serial when it is enabled
      if (s == 1 && !(i_nv_serial_en && (p == 1 || p == 2))) begin
        e[f] = w[p] ^ i_nv_act_low[p];
      end
      // serial drives bypass only with its permit bit set
      if (s == 2 && i_nv_serial_en && f != 6 && (f != 1 || e[1])) begin
        e[f] = i_ser_ctrl[f];
      end
    end
    return e;
  endfunction
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // reset is already low here; config must settle before release
  task automatic restart();
    int n;
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK({o_div_clear, o_pll_unlock_force, o_core_rst_b, ctl}, {3'h6, FN_RST})
    `CHK({o_user_pull_up, o_user_pull_dn}, 8'hf0)
    i_rst_b = 1;
    n = 0;
    while (o_core_rst_b !== 1'b1 && n < 50) begin
      if (n == 2) `CHK(o_out_disable_rst, !i_nv_fanout_direct)
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    `CHK(n inside {[POR_CYCLES_P:POR_CYCLES_P+4]}, 1'b1)
  endtask
  task automatic phase(int iters);
    logic [3:0] w;
    repeat (iters) begin
      drv = 4'($urandom);
      rel = 4'($urandom);
      i_ser_ctrl = 7'($urandom);
      {i_ser_sda_pull, i_pll_lock} = 2'($urandom);
      // lock out plus pin sync is the longest path
      repeat (9) @(posedge i_sys_clk);
      #1;
      w = (rel & i_nv_pull_up) | (~rel & drv);
      if (i_nv_serial_en && i_ser_sda_pull) w[1] = 1'b0;
      if (i_nv_lock_on_pin) w[0] = i_pll_lock ^ i_nv_act_low[0];
      `CHK(ctl, model(w))
      `CHK({o_user_pull_up, o_user_pull_dn}, {i_nv_pull_up, ~i_nv_pull_up})
      `CHK({o_ser_enable, o_ser_scl, o_ser_sda}, i_nv_serial_en ? {1'b1, w[2], w[1]} : 3'h3)
      `CHK(o_user_pin_oe, {i_nv_serial_en & i_ser_sda_pull, i_nv_lock_on_pin})
      if (i_nv_lock_on_pin) `CHK(o_user_pin[0], w[0])
      if (o_user_pin_oe[1]) `CHK(o_user_pin[1], 1'b0)
    end
  endtask
  initial begin
    void'($urandom(93106));
    repeat (8) @(posedge i_sys_clk);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      #1;
      // the board pulls reset low before reconfiguring
      i_rst_b = 0;
      {i_nv_act_low, i_nv_pull_up, i_nv_fn_pin} = 22'($urandom);
      {i_nv_fn_src, i_nv_fn_fixed} = 21'($urandom);
      {i_nv_serial_en, i_nv_lock_on_pin, i_nv_fanout_direct} = 3'($urandom);
      if (k < 4) begin
        i_nv_fn_src = srct[k];
        i_nv_serial_en = k inside {1, 2};
        i_nv_fn_fixed[1] = k == 2;
        i_nv_lock_on_pin = k == 2;
        i_nv_fn_pin[1:0] = 2'h2;
      end
      restart();
      phase(12);
    end
    end_of_test();
  end
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
endmodule
